/* inc/rsb_defs.svh */
`ifndef RSB_DEFS_SVH
`define RSB_DEFS_SVH

// Timing
`define RSB_CLK_PERIOD_NS   50
`define RSB_HOLD_TIME_NS    1000
`define RSB_HOLD_CYCLES     ((`RSB_HOLD_TIME_NS + `RSB_CLK_PERIOD_NS - 1) / `RSB_CLK_PERIOD_NS)

// Register offsets (byte addresses)
`define RSB_OFF_CTRL        8'h00
`define RSB_OFF_STATUS      8'h04
`define RSB_OFF_VECTOR_TABLE_OFFSET_REGISTER        8'h08
`define RSB_OFF_FLASH_OPT   8'h0C
`define RSB_OFF_PF_CTRL     8'h10
`define RSB_OFF_PF_WIDTH    8'h14
`define RSB_OFF_FORCE_MODE  8'h18
`define RSB_OFF_SYS_OPT1    8'h1C
`define RSB_OFF_PMCTRL      8'h20
`define RSB_OFF_STOPCTRL    8'h24
`define RSB_OFF_PMSTAT      8'h28
`define RSB_OFF_SYSFILE     8'h40
`define RSB_OFF_VBATFILE    8'h60
`define RSB_FILE_WORDS      8

// Domain bit positions and per-class masks
`define RSB_DOM_PMC         0
`define RSB_DOM_SIM         1
`define RSB_DOM_SMC         2
`define RSB_DOM_RCM         3
`define RSB_DOM_LOW_LEAKAGE_WAKEUP_DOMAIN        4
`define RSB_DOM_LOW_POWER_TIMER       5
`define RSB_DOM_OTHER       6
`define RSB_DOM_NUM         7
`define RSB_MASK_POR        7'h7F
`define RSB_MASK_LOW_LEAKAGE_WAKEUP_DOMAIN       7'h4A
`define RSB_MASK_SYS        7'h5F

// Boot option byte inside the 16-byte configuration field
`define RSB_CFG_BITS        128
`define RSB_OPT_LSB         104
`define RSB_OPT_ROM_BIT     1
`define RSB_OPT_QSPI_BIT    2
`define RSB_ROM_BASE        32'h0F00_0000
`define RSB_FLASH_BASE      32'h0000_0000
`define RSB_VECTOR_TABLE_OFFSET_REGISTER_MASK       32'hFFFF_FF80

// Control and status fields
`define RSB_CTRL_SWRST_BIT  0
`define RSB_ST_BOOT_ROM     16
`define RSB_ST_BOOT_QSPI    17
`define RSB_ST_LOADER       18
`define RSB_ST_BLANK        19
`define RSB_CAUSE_POR       9'h001
`define RSB_CAUSE_LOW_LEAKAGE_WAKEUP_DOMAIN      9'h002
`define RSB_CAUSE_PIN       9'h004

// Reset values
`define RSB_BYTE_RST        8'h00
`define RSB_WORD_RST        32'h0000_0000

`endif

/* inc/rsb_pkg.sv */
package rsb_pkg;

    typedef enum logic [1:0] {
        RSB_ST_IDLE    = 2'b00,
        RSB_ST_HOLD    = 2'b01,
        RSB_ST_RELEASE = 2'b10,
        RSB_ST_BOOT    = 2'b11
    } rsb_state_t;

    typedef enum logic [1:0] {
        RSB_CLS_POR  = 2'b00,
        RSB_CLS_LOW_LEAKAGE_WAKEUP_DOMAIN = 2'b01,
        RSB_CLS_PIN  = 2'b10,
        RSB_CLS_SYS  = 2'b11
    } rsb_class_t;

endpackage

/* hw/rsb_rst_sync.sv */
`timescale 1ns/100ps
// Asserts one edge after req, releases two edges after req drops
module rsb_rst_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic req,
    output logic      rst_n
);
    logic stage_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_reg <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            stage_reg <= ~req;
            rst_n     <= stage_reg & ~req;
        end
    end
endmodule

/* hw/rsb_top.sv */
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "rsb_defs.svh"

// Summary of operation
// - Pin reset clears all but clock-calendar, timer
// - Other system resets match pin, keep filters
// - Keep option register 1 and mode registers
// - Wakeup reset partial; pin driven if pin woke
// - Power-on reset clears all seven domains incl timer, not calendar
// - Battery reset alone covers calendar, battery file
// - 32-byte system file cleared only at power-on
// - Boot from internal flash or ROM
// - Load option byte into flash option register
// - Read settings from 16-byte configuration field
// - Blank part boots ROM; vectors follow source
// - ROM boot: loader mode or serial flash boot
// - Software-writable vector table offset register
module rsb_top
    import rsb_pkg::*;
#(
    parameter int HOLD_CYCLES = `RSB_HOLD_CYCLES,
    parameter int CNT_W       = 12
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      vbat_por_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      reset_pin_in,
    output logic                           reset_pin_out,
    output logic                           reset_pin_oe,
    input  wire logic                      low_leakage_wakeup_domain_wake_req,
    input  wire logic                      wake_by_pin,
    input  wire logic                      watchdog_reset,
    input  wire logic                      stop_ack_error_reset,
    input  wire logic                      lockup_reset,
    input  wire logic                      debug_port_system_reset,
    input  wire logic                      debug_reset,
    input  wire logic [`RSB_CFG_BITS-1:0]  cfg_field,
    output logic                           power_control_domain_rst_n,
    output logic                           system_integration_domain_rst_n,
    output logic                           mode_control_domain_rst_n,
    output logic                           reset_control_domain_rst_n,
    output logic                           low_leakage_wakeup_domain_rst_n,
    output logic                           low_power_timer_rst_n,
    output logic                           other_modules_rst_n,
    output logic                           rtc_rst_n,
    output logic                           boot_from_rom,
    output logic                           boot_loader_mode,
    output logic                           boot_qspi,
    output logic      [31:0]               vector_base
);
    rsb_state_t             state_reg;
    rsb_state_t             state_next;
    rsb_class_t             cls_reg;
    rsb_class_t             cls_next;
    logic [CNT_W-1:0]       cnt_reg;
    logic                   pin_s1_reg;
    logic                   pin_s2_reg;
    logic                   sw_req_reg;
    logic                   oe_reg;
    logic [8:0]             cause_reg;
    logic [7:0]             flash_opt_reg;
    logic                   blank_reg;
    logic [31:0]            vector_table_offset_register_reg;
    logic [7:0]             pf_ctrl_reg;
    logic [7:0]             pf_width_reg;
    logic [7:0]             force_mode_reg;
    logic [7:0]             sys_opt1_reg;
    logic [7:0]             pmctrl_reg;
    logic [7:0]             stopctrl_reg;
    logic [7:0]             pmstat_reg;
    logic [31:0]            sysfile_mem [`RSB_FILE_WORDS];
    logic [31:0]            vbatfile_mem [`RSB_FILE_WORDS];
    logic [`RSB_DOM_NUM-1:0] dom_rst_n;

    // Pin reset is asynchronous to pclk; two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            pin_s1_reg <= reset_pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Source decode; full system resets win over the partial wakeup reset
    wire       in_idle   = (state_reg == RSB_ST_IDLE);
    wire       in_hold   = (state_reg == RSB_ST_HOLD);
    wire       pin_evt   = ~pin_s2_reg;
    wire [5:0] sys_vec   = {debug_reset, debug_port_system_reset, lockup_reset,
                            sw_req_reg, stop_ack_error_reset, watchdog_reset};
    wire       sys_evt   = |sys_vec;
    wire       any_evt   = pin_evt | sys_evt | low_leakage_wakeup_domain_wake_req;
    wire       hold_done = (cnt_reg == CNT_W'(HOLD_CYCLES - 1));
    wire       low_leakage_wakeup_domain_pin  = low_leakage_wakeup_domain_wake_req & wake_by_pin;

    always_comb begin
        state_next = state_reg;
        cls_next   = cls_reg;
        unique case (state_reg)
            RSB_ST_IDLE: begin
                if (any_evt) begin
                    state_next = RSB_ST_HOLD;
                    if (pin_evt)
                        cls_next = RSB_CLS_PIN;
                    else if (sys_evt)
                        cls_next = RSB_CLS_SYS;
                    else
                        cls_next = RSB_CLS_LOW_LEAKAGE_WAKEUP_DOMAIN;
                end
            end
            RSB_ST_HOLD: begin
                if (hold_done)
                    state_next = RSB_ST_RELEASE;
            end
            // The pin may still be held low from outside
            RSB_ST_RELEASE: begin
                if (pin_s2_reg)
                    state_next = RSB_ST_BOOT;
            end
            RSB_ST_BOOT: begin
                state_next = RSB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RSB_ST_HOLD;
            cls_reg   <= RSB_CLS_POR;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cls_reg   <= cls_next;
            cnt_reg   <= in_hold ? cnt_reg + CNT_W'(1) : '0;
        end
    end

    // Pin drive: low during every full reset, for wakeup only if the pin woke us
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_reg    <= 1'b1;
            cause_reg <= `RSB_CAUSE_POR;
        end else if (in_idle && any_evt) begin
            oe_reg    <= pin_evt | sys_evt | low_leakage_wakeup_domain_pin;
            cause_reg <= {sys_vec, pin_evt, low_leakage_wakeup_domain_wake_req & ~pin_evt & ~sys_evt, 1'b0};
        end else if (in_hold && hold_done) begin
            oe_reg    <= 1'b0;
        end
    end
    assign reset_pin_oe  = oe_reg;
    assign reset_pin_out = 1'b0;

    // Domain requests from the class table
    wire [`RSB_DOM_NUM-1:0] cls_mask =
        (cls_reg == RSB_CLS_POR)  ? `RSB_MASK_POR :
        (cls_reg == RSB_CLS_LOW_LEAKAGE_WAKEUP_DOMAIN) ? `RSB_MASK_LOW_LEAKAGE_WAKEUP_DOMAIN :
                                    `RSB_MASK_SYS;
    wire [`RSB_DOM_NUM-1:0] dom_req = in_hold ? cls_mask : '0;

    // One synchroniser per domain; equal timing releases all on one edge
    genvar g;
    generate
        for (g = 0; g < `RSB_DOM_NUM; g++) begin : g_dom
            rsb_rst_sync u_sync (
                .clk    (pclk),
                .arst_n (presetn),
                .req    (dom_req[g]),
                .rst_n  (dom_rst_n[g])
            );
        end
    endgenerate

    // Battery domain sees only its own power-on reset
    rsb_rst_sync u_vbat_sync (
        .clk    (pclk),
        .arst_n (vbat_por_n),
        .req    (1'b0),
        .rst_n  (rtc_rst_n)
    );

    assign power_control_domain_rst_n      = dom_rst_n[`RSB_DOM_PMC];
    assign system_integration_domain_rst_n = dom_rst_n[`RSB_DOM_SIM];
    assign mode_control_domain_rst_n       = dom_rst_n[`RSB_DOM_SMC];
    assign reset_control_domain_rst_n      = dom_rst_n[`RSB_DOM_RCM];
    assign low_leakage_wakeup_domain_rst_n = dom_rst_n[`RSB_DOM_LOW_LEAKAGE_WAKEUP_DOMAIN];
    assign low_power_timer_rst_n           = dom_rst_n[`RSB_DOM_LOW_POWER_TIMER];
    assign other_modules_rst_n             = dom_rst_n[`RSB_DOM_OTHER];

    // Boot decision from the configuration field
    wire [7:0] opt_byte = cfg_field[`RSB_OPT_LSB +: 8];
    wire       cfg_blank = &cfg_field;
    wire       sel_rom   = cfg_blank | opt_byte[`RSB_OPT_ROM_BIT];
    wire       sel_qspi  = sel_rom & ~cfg_blank & opt_byte[`RSB_OPT_QSPI_BIT];
    wire [31:0] sel_base = sel_rom ? `RSB_ROM_BASE : `RSB_FLASH_BASE;
    wire       in_boot   = (state_reg == RSB_ST_BOOT);

    // APB: one wait state, writes land when pready is seen high
    wire        acc      = psel & penable;
    wire        fire     = acc & pready;
    wire        wr_ok    = fire & pwrite & ~in_hold;
    wire [4:0]  rd_idx   = paddr[6:2];
    wire        hit_sys  = (paddr[7:5] == 3'(`RSB_OFF_SYSFILE >> 5));
    wire        hit_vbat = (paddr[7:5] == 3'(`RSB_OFF_VBATFILE >> 5));
    wire [2:0]  file_idx = paddr[4:2];
    wire        hit_reg  = (paddr[7:6] == 2'b00) && (rd_idx <= 5'(`RSB_OFF_PMSTAT >> 2));
    wire        mapped   = (hit_reg || hit_sys || hit_vbat) && (paddr[1:0] == 2'b00);
    wire [31:0] status_w = {12'h000, blank_reg, boot_loader_mode, boot_qspi, boot_from_rom,
                            7'h00, cause_reg};
    wire [31:0] rd_mux   =
        !mapped                        ? `RSB_WORD_RST :
        hit_sys                        ? sysfile_mem[file_idx] :
        hit_vbat                       ? vbatfile_mem[file_idx] :
        (paddr == `RSB_OFF_STATUS)     ? status_w :
        (paddr == `RSB_OFF_VECTOR_TABLE_OFFSET_REGISTER)       ? vector_table_offset_register_reg :
        (paddr == `RSB_OFF_FLASH_OPT)  ? {24'h00_0000, flash_opt_reg} :
        (paddr == `RSB_OFF_PF_CTRL)    ? {24'h00_0000, pf_ctrl_reg} :
        (paddr == `RSB_OFF_PF_WIDTH)   ? {24'h00_0000, pf_width_reg} :
        (paddr == `RSB_OFF_FORCE_MODE) ? {24'h00_0000, force_mode_reg} :
        (paddr == `RSB_OFF_SYS_OPT1)   ? {24'h00_0000, sys_opt1_reg} :
        (paddr == `RSB_OFF_PMCTRL)     ? {24'h00_0000, pmctrl_reg} :
        (paddr == `RSB_OFF_STOPCTRL)   ? {24'h00_0000, stopctrl_reg} :
        (paddr == `RSB_OFF_PMSTAT)     ? {24'h00_0000, pmstat_reg} :
                                         `RSB_WORD_RST;
    wire wr_sys   = wr_ok & hit_sys & mapped;
    wire wr_vbat  = wr_ok & hit_vbat & mapped;
    wire wr_reg   = wr_ok & hit_reg & mapped;
    wire rcm_clr  = in_hold & ((cls_reg == RSB_CLS_PIN) | (cls_reg == RSB_CLS_LOW_LEAKAGE_WAKEUP_DOMAIN));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `RSB_WORD_RST;
        end else begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            if (acc && !pready)
                prdata <= pwrite ? `RSB_WORD_RST : rd_mux;
        end
    end

    // Software reset request, a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sw_req_reg <= 1'b0;
        else
            sw_req_reg <= wr_reg && (paddr == `RSB_OFF_CTRL) && pwdata[`RSB_CTRL_SWRST_BIT];
    end

    // Boot results and vector table offset, reloaded on every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_opt_reg    <= `RSB_BYTE_RST;
            blank_reg        <= 1'b0;
            boot_from_rom    <= 1'b0;
            boot_qspi        <= 1'b0;
            boot_loader_mode <= 1'b0;
            vector_base      <= `RSB_WORD_RST;
            vector_table_offset_register_reg         <= `RSB_WORD_RST;
        end else if (in_boot) begin
            flash_opt_reg    <= opt_byte;
            blank_reg        <= cfg_blank;
            boot_from_rom    <= sel_rom;
            boot_qspi        <= sel_qspi;
            boot_loader_mode <= sel_rom & ~sel_qspi;
            vector_base      <= sel_base;
            vector_table_offset_register_reg         <= sel_base;
        end else if (wr_reg && paddr == `RSB_OFF_VECTOR_TABLE_OFFSET_REGISTER) begin
            vector_table_offset_register_reg <= pwdata & `RSB_VECTOR_TABLE_OFFSET_REGISTER_MASK;
        end
    end

    // Filter and force-mode settings survive all but pin, wakeup and power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_ctrl_reg    <= `RSB_BYTE_RST;
            pf_width_reg   <= `RSB_BYTE_RST;
            force_mode_reg <= `RSB_BYTE_RST;
        end else if (rcm_clr) begin
            pf_ctrl_reg    <= `RSB_BYTE_RST;
            pf_width_reg   <= `RSB_BYTE_RST;
            force_mode_reg <= `RSB_BYTE_RST;
        end else if (wr_reg) begin
            if (paddr == `RSB_OFF_PF_CTRL)
                pf_ctrl_reg <= pwdata[7:0];
            if (paddr == `RSB_OFF_PF_WIDTH)
                pf_width_reg <= pwdata[7:0];
            if (paddr == `RSB_OFF_FORCE_MODE)
                force_mode_reg <= pwdata[7:0];
        end
    end

    // Option 1 and power-mode registers: only power-on clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_opt1_reg <= `RSB_BYTE_RST;
            pmctrl_reg   <= `RSB_BYTE_RST;
            stopctrl_reg <= `RSB_BYTE_RST;
            pmstat_reg   <= `RSB_BYTE_RST;
        end else begin
            if (wr_reg && paddr == `RSB_OFF_SYS_OPT1)
                sys_opt1_reg <= pwdata[7:0];
            if (wr_reg && paddr == `RSB_OFF_PMCTRL)
                pmctrl_reg <= pwdata[7:0];
            if (wr_reg && paddr == `RSB_OFF_STOPCTRL)
                stopctrl_reg <= pwdata[7:0];
            // Status mirrors the mode last requested, frozen while in reset
            if (!in_hold)
                pmstat_reg <= pmctrl_reg;
        end
    end

    // Retained system file; array reset only by power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `RSB_FILE_WORDS; i++)
                sysfile_mem[i] <= `RSB_WORD_RST;
        end else if (wr_sys) begin
            sysfile_mem[file_idx] <= pwdata;
        end
    end

    // Battery file sits on the battery reset alone
    always_ff @(posedge pclk or negedge vbat_por_n) begin
        if (!vbat_por_n) begin
            for (int i = 0; i < `RSB_FILE_WORDS; i++)
                vbatfile_mem[i] <= `RSB_WORD_RST;
        end else if (wr_vbat) begin
            vbatfile_mem[file_idx] <= pwdata;
        end
    end

    a_pin_domains: assert property (@(posedge pclk) disable iff (!presetn)
        (in_hold && cls_reg == RSB_CLS_PIN) |=> (!power_control_domain_rst_n && !other_modules_rst_n
            && !low_leakage_wakeup_domain_rst_n && low_power_timer_rst_n))
        else $error("pin reset domain set wrong");
    a_sys_keep_filter: assert property (@(posedge pclk) disable iff (!presetn)
        (in_hold && cls_reg == RSB_CLS_SYS) |=> ($stable(pf_ctrl_reg) && $stable(force_mode_reg)))
        else $error("filter setting lost on system reset");
    a_keep_mode_regs: assert property (@(posedge pclk) disable iff (!presetn)
        in_hold |=> ($stable(sys_opt1_reg) && $stable(pmctrl_reg) && $stable(stopctrl_reg)))
        else $error("retained register changed in reset");
    a_low_leakage_wakeup_domain_domains: assert property (@(posedge pclk) disable iff (!presetn)
        (in_hold && cls_reg == RSB_CLS_LOW_LEAKAGE_WAKEUP_DOMAIN) |=> (power_control_domain_rst_n && mode_control_domain_rst_n
            && low_leakage_wakeup_domain_rst_n && !system_integration_domain_rst_n))
        else $error("wakeup reset domain set wrong");
    a_low_leakage_wakeup_domain_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (in_idle && low_leakage_wakeup_domain_wake_req && !pin_evt && !sys_evt) |=> (reset_pin_oe == $past(wake_by_pin)))
        else $error("pin drive wrong on wakeup reset");
    a_por_all: assert property (@(posedge pclk) disable iff (!presetn)
        (in_hold && cls_reg == RSB_CLS_POR) |=> (!low_power_timer_rst_n && !other_modules_rst_n))
        else $error("power-on reset missed a domain");
    a_rtc_isolated: assert property (@(posedge pclk) disable iff (!presetn || !vbat_por_n)
        $rose(rtc_rst_n) |-> ##1 rtc_rst_n [*8])
        else $error("calendar reset moved by other source");
    a_sysfile_keep: assert property (@(posedge pclk) disable iff (!presetn)
        in_hold |=> $stable(sysfile_mem[0]))
        else $error("system file changed in reset");
    a_boot_blank: assert property (@(posedge pclk) disable iff (!presetn)
        (in_boot && cfg_blank) |=> (boot_from_rom && vector_base == `RSB_ROM_BASE && vector_table_offset_register_reg == `RSB_ROM_BASE))
        else $error("blank part not booting from ROM");
    a_boot_flash: assert property (@(posedge pclk) disable iff (!presetn)
        (in_boot && !sel_rom) |=> (!boot_from_rom && !boot_qspi && vector_base == `RSB_FLASH_BASE))
        else $error("flash boot not selected");
    a_rom_mode: assert property (@(posedge pclk) disable iff (!presetn)
        boot_from_rom |-> (boot_qspi != boot_loader_mode))
        else $error("ROM boot mode not exclusive");
    a_opt_load: assert property (@(posedge pclk) disable iff (!presetn)
        in_boot |=> (flash_opt_reg == $past(opt_byte)))
        else $error("option byte not loaded");
    a_release_together: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(other_modules_rst_n) && cls_reg != RSB_CLS_LOW_LEAKAGE_WAKEUP_DOMAIN) |-> (power_control_domain_rst_n
            && system_integration_domain_rst_n && reset_control_domain_rst_n && mode_control_domain_rst_n))
        else $error("domains left reset on different edges");
endmodule

/* testbench/rsb_far_end.sv */
`timescale 1ns/100ps
// Reset pin with its pull-up, and the flash configuration field
module rsb_far_end (
    input  wire logic         reset_pin_out,
    input  wire logic         reset_pin_oe,
    input  wire logic         ext_low,
    input  wire logic         blank,
    input  wire logic [7:0]   opt_byte,
    output logic              reset_pin_in,
    output logic [127:0]      cfg_field
);
    // Pull-up wins only when nobody pulls low
    assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || ext_low);
    // Erased cells read as ones, so only the option byte differs
    assign cfg_field = blank ? {128{1'b1}} : {16'hFFFF, opt_byte, {104{1'b1}}};
endmodule

/* testbench/reset_scope_and_boot_select_tb.sv */
`timescale 1ns/100ps
`include "rsb_defs.svh"
module reset_scope_and_boot_select_tb;
    import rsb_pkg::*;
    logic         pclk, presetn, vbat_por_n, psel, penable, pwrite, pready, pslverr, er;
    logic         ext_low, blank, wake_by_pin, low_leakage_wakeup_domain_wake_req, pin_in, pin_out, pin_oe, rtc_rst_n;
    logic         rom, ldr, qspi;
    logic [7:0]   paddr, opt_byte;
    logic [31:0]  pwdata, prdata, vector_base, rd;
    logic [4:0]   src;
    logic [6:0]   dom;
    logic [127:0] cfg;
    int           error_cnt, tests_run;
    int           cyc = 0;

    rsb_far_end far (.reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .ext_low(ext_low), .blank(blank),
        .opt_byte(opt_byte), .reset_pin_in(pin_in), .cfg_field(cfg));
    // Short hold keeps each reset sequence well under fifty cycles
    rsb_top #(.HOLD_CYCLES(2)) uut (.pclk(pclk), .presetn(presetn), .vbat_por_n(vbat_por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .low_leakage_wakeup_domain_wake_req(low_leakage_wakeup_domain_wake_req), .wake_by_pin(wake_by_pin), .watchdog_reset(src[0]),
        .stop_ack_error_reset(src[1]), .lockup_reset(src[2]), .debug_port_system_reset(src[3]),
        .debug_reset(src[4]), .cfg_field(cfg), .power_control_domain_rst_n(dom[0]),
        .system_integration_domain_rst_n(dom[1]), .mode_control_domain_rst_n(dom[2]),
        .reset_control_domain_rst_n(dom[3]), .low_leakage_wakeup_domain_rst_n(dom[4]),
        .low_power_timer_rst_n(dom[5]), .other_modules_rst_n(dom[6]), .rtc_rst_n(rtc_rst_n),
        .boot_from_rom(rom), .boot_loader_mode(ldr), .boot_qspi(qspi), .vector_base(vector_base));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (n >= 20) chk(32'h0000_0000, 32'h0000_0001, "no pready");
    endtask

    // Raises one source for three cycles, then gathers which outputs went active
    task automatic fire(input int k, output logic [8:0] s);
        s = '0;
        @(posedge pclk);
        if (k < 5) src[k] <= 1'b1;
        else if (k == 5) ext_low <= 1'b1;
        else {low_leakage_wakeup_domain_wake_req, wake_by_pin} <= {1'b1, k[0]};
        for (int i = 0; i < 50; i++) begin
            @(posedge pclk);
            s |= {pin_oe, ~rtc_rst_n, ~dom};
            if (i == 2) {src, ext_low, low_leakage_wakeup_domain_wake_req, wake_by_pin} <= '0;
        end
    endtask

    task automatic t_sys();
        logic [8:0] s;
        apb(1'b1, `RSB_OFF_SYS_OPT1, 32'h0000_00A5);
        apb(1'b1, `RSB_OFF_PMCTRL, 32'h0000_005A);
        apb(1'b1, `RSB_OFF_PF_CTRL, 32'h0000_003C);
        apb(1'b1, `RSB_OFF_SYSFILE + 8'h1C, 32'h1234_5678);
        apb(1'b1, `RSB_OFF_VBATFILE, 32'h0BAD_F00D);
        for (int k = 0; k < 5; k++) begin
            fire(k, s);
            chk({23'h0, s}, 32'h0000_015F, "system scope");
        end
        apb(1'b0, `RSB_OFF_PF_CTRL, '0);
        chk(rd, 32'h0000_003C, "filter kept");
        apb(1'b0, `RSB_OFF_SYS_OPT1, '0);
        chk(rd, 32'h0000_00A5, "option 1 kept");
        apb(1'b0, `RSB_OFF_PMSTAT, '0);
        chk(rd, 32'h0000_005A, "mode status kept");
        fire(6, s);
        chk({23'h0, s}, 32'h0000_004A, "wake scope");
        fire(7, s);
        chk({23'h0, s}, 32'h0000_014A, "wake by pin");
        apb(1'b0, `RSB_OFF_PF_CTRL, '0);
        chk(rd, 32'h0000_0000, "wake clears filter");
        apb(1'b1, `RSB_OFF_PF_CTRL, 32'h0000_003C);
        fire(5, s);
        chk({23'h0, s}, 32'h0000_015F, "pin scope");
        apb(1'b0, `RSB_OFF_PF_CTRL, '0);
        chk(rd, 32'h0000_0000, "pin clears filter");
        apb(1'b0, `RSB_OFF_SYSFILE + 8'h1C, '0);
        chk(rd, 32'h1234_5678, "file kept");
        apb(1'b0, `RSB_OFF_VBATFILE, '0);
        chk(rd, 32'h0BAD_F00D, "battery file kept");
        @(posedge pclk);
        vbat_por_n <= 1'b0;
        @(posedge pclk);
        vbat_por_n <= 1'b1;
        chk({24'h0, rtc_rst_n, dom}, 32'h0000_007F, "battery reset alone");
        apb(1'b0, `RSB_OFF_VBATFILE, '0);
        chk(rd, 32'h0000_0000, "battery file cleared");
        apb(1'b0, `RSB_OFF_SYSFILE + 8'h1C, '0);
        chk(rd, 32'h1234_5678, "file kept on battery reset");
        $display("test system resets done");
    endtask

    task automatic t_boot();
        logic [7:0] ob [3] = '{8'h00, 8'h02, 8'h06};
        logic [2:0] ex [3] = '{3'b000, 3'b110, 3'b101};
        for (int i = 0; i < 3; i++) begin
            {blank, opt_byte} <= {1'b0, ob[i]};
            apb(1'b1, `RSB_OFF_CTRL, 32'h0000_0001);
            repeat (50) @(posedge pclk);
            chk({29'h0, rom, ldr, qspi}, {29'h0, ex[i]}, "boot select");
            chk(vector_base, ex[i][2] ? `RSB_ROM_BASE : `RSB_FLASH_BASE, "vectors");
            apb(1'b0, `RSB_OFF_FLASH_OPT, '0);
            chk(rd, {24'h0, ob[i]}, "option byte");
            apb(1'b0, `RSB_OFF_STATUS, '0);
            chk(rd, {12'h000, 1'b0, ex[i][1], ex[i][0], ex[i][2], 16'h0020}, "status");
        end
        apb(1'b1, `RSB_OFF_VECTOR_TABLE_OFFSET_REGISTER, 32'hFFFF_FFFF);
        apb(1'b0, `RSB_OFF_VECTOR_TABLE_OFFSET_REGISTER, '0);
        chk(rd, `RSB_VECTOR_TABLE_OFFSET_REGISTER_MASK, "offset register");
        apb(1'b0, 8'h30, '0);
        chk({er, rd[30:0]}, 32'h8000_0000, "unmapped");
        $display("test boot done");
    endtask

    initial begin
        {presetn, vbat_por_n, psel, penable, pwrite, ext_low, wake_by_pin, low_leakage_wakeup_domain_wake_req} = '0;
        {src, paddr, pwdata, error_cnt, tests_run} = '0;
        {blank, opt_byte} = 9'h1FF;
        repeat (3) @(posedge pclk);
        chk({24'h0, rtc_rst_n, dom}, 32'h0000_0000, "held in reset");
        presetn <= 1'b1;
        vbat_por_n <= 1'b1;
        repeat (50) @(posedge pclk);
        chk({24'h0, rtc_rst_n, dom}, 32'h0000_00FF, "released");
        chk({29'h0, rom, ldr, qspi}, 32'h0000_0006, "blank boot");
        chk(vector_base, `RSB_ROM_BASE, "blank vectors");
        t_sys();
        t_boot();
        close_out();
    end
endmodule
